// >>> rirl_indication.sv
// Indication and reset logic of a protection relay module.
// Assumes stage, button and control inputs come from pins (synchronised here except the bank buttons)
// and a register master on mclk using the plain strobe port.
//
// Function
// - Bank changes from the serial bus or buttons are ignored while external inputs choose the bank.
// - Resets are accepted from the buttons, an external control input and the serial bus.
// - Reset button clears indicators, program with dark display also unlatches, both also erase.
// - External inputs reset only when an enabling switch bit selects one of three levels.
// - First serial reset command clears and unlatches, the second also erases records.
// - Trip codes and the trip lamp stay lit until an explicit reset.
// - Start codes clear when the stage resets unless the per-stage hold switch keeps them.
// - A started stage that operates shows its operate code instead of its start code.
// - One trip lamp serves all stages, its behaviour set by one switchgroup.
// - The displayed code is readable over the serial port with the same value.
// - Codes are odd for start and next even for operate per stage, 9 for high earth-fault start.
// - Latched indicators never affect protection or output behaviour.
// - On operation a lamp lights per phase above start level, cleared by the reset button.
// - A permanent fault lights the internal-fault lamp and alarm output together.
// - The fault code shows a leading one and a code, and no reset clears it.
// - Trip outputs with the self-holding switch set stay on until an unlatching reset.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module rirl_indication #(
    parameter int NST = rirl_pkg::NUM_STAGES,
    parameter int NOUT = rirl_pkg::NUM_OUTS,
    parameter int NPH = rirl_pkg::NUM_PHASES,
    parameter int REC_DEPTH = rirl_pkg::MAX_SERIAL_EVENTS
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [NST-1:0] stage_start,
    input wire logic [NST-1:0] stage_oper,
    input wire logic [NPH-1:0] phase_over,
    input wire logic [NOUT-1:0] trip_cause,
    input wire logic btn_reset_n,
    input wire logic btn_program_n,
    input wire logic display_dark,
    input wire logic ext_ctrl_in_a,
    input wire logic ext_ctrl_in_b,
    input wire logic ext_remote_reset_in,
    input wire logic btn_bank_req,
    input wire logic btn_bank_val,
    input wire logic fault_detect,
    input wire logic [rirl_pkg::FAULT_W-1:0] fault_code_in,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic [rirl_pkg::CODE_W-1:0] display_code,
    output logic trip_lamp,
    output logic [NPH-1:0] phase_lamp,
    output logic [NOUT-1:0] trip_out,
    output logic internal_fault_lamp,
    output logic fault_alarm_out,
    output logic [rirl_pkg::FAULT_W:0] fault_display,
    output logic active_bank,
    output logic irq
);
    localparam int RAW = NST * 2 + NPH + NOUT + 7;
    localparam int RA = $clog2(REC_DEPTH);

    typedef struct packed {
        logic [RAW-1:0] s1;
        logic [RAW-1:0] s2;
        logic [NST-1:0] start_ind;
        logic [NST-1:0] oper_ind;
        logic [NPH-1:0] phase_ind;
        logic [NOUT-1:0] hold_out;
        logic lamp;
        logic fault;
        logic [rirl_pkg::FAULT_W-1:0] fcode;
        logic [NST-1:0] start_hold_sg;
        logic [NOUT-1:0] out_hold_sg;
        logic [rirl_pkg::LAMP_SG_W-1:0] lamp_sg;
        logic [rirl_pkg::SGB_W-1:0] ext_input_switchgroup;
        logic serial_second;
        logic bank;
        logic [rirl_pkg::IRQ_W-1:0] status;
        logic [rirl_pkg::IRQ_W-1:0] mask;
        logic [RA-1:0] rec_ptr;
        logic [NST-1:0] oper_prev;
        logic [7:0] rdata;
        logic rd_rec;
    } rirl_state_s;

    rirl_state_s q;
    rirl_state_s d;

    logic [NST-1:0] st_s;
    logic [NST-1:0] op_s;
    logic [NPH-1:0] ph_s;
    logic [NOUT-1:0] tc_s;
    logic b_rst;
    logic b_prg;
    logic dark_s;
    logic in_a;
    logic in_b;
    logic in_r;
    logic bank_req_s;
    logic bank_val_s;
    logic flt_s;
    logic ext_any;
    logic clr_ind;
    logic clr_unl;
    logic clr_erase;
    logic [rirl_pkg::CODE_W-1:0] code;
    logic [NST-1:0] oper_new;
    logic rec_wr;
    logic [7:0] rec_rd;

    assign {st_s, op_s, ph_s, tc_s, b_rst, b_prg, dark_s, in_a, in_b, in_r, flt_s} = q.s2;
    assign bank_req_s = btn_bank_req;
    assign bank_val_s = btn_bank_val;
    assign ext_any = in_a | in_b | in_r;
    assign oper_new = op_s & ~q.oper_prev;
    assign rec_wr = |oper_new;

    // Lowest-numbered active stage wins the display
    always_comb begin
        code = rirl_pkg::CODE_NONE;
        for (int i = NST - 1; i >= 0; i--) begin
            if (q.oper_ind[i]) begin
                code = 4'(2 * i + 2);
            end else if (q.start_ind[i]) begin
                code = 4'(2 * i + 1);
            end
        end
    end

    always_comb begin
        logic ext_reset_req;
        logic serial_a;
        logic serial_b;
        ext_reset_req = 1'b0;
        serial_a = 1'b0;
        serial_b = 1'b0;
        d = q;
        d.s1 = {stage_start, stage_oper, phase_over, trip_cause, ~btn_reset_n, ~btn_program_n,
                display_dark, ext_ctrl_in_a, ext_ctrl_in_b, ext_remote_reset_in, fault_detect};
        d.s2 = q.s1;
        d.oper_prev = op_s;
        d.rdata = 8'h00;
        // Record memory answers from its own read register
        d.rd_rec = rd && addr == rirl_pkg::ADDR_RECORD;

        // Serial command decode
        if (wr && addr == rirl_pkg::ADDR_CMD) begin
            serial_a = wdata[rirl_pkg::CMD_RESET_A_BIT];
            serial_b = wdata[rirl_pkg::CMD_RESET_B_BIT];
            if (!q.ext_input_switchgroup[rirl_pkg::SGB_BANK_BIT]) begin
                if (wdata[rirl_pkg::CMD_BANK_BIT]) begin
                    d.bank = ~q.bank;
                end
            end
        end
        if (wr && addr == rirl_pkg::ADDR_CFG) begin
            d.start_hold_sg = wdata[NST-1:0];
        end
        if (wr && addr == rirl_pkg::ADDR_BANK) begin
            d.out_hold_sg = wdata[NOUT-1:0];
            d.lamp_sg = wdata[4 +: rirl_pkg::LAMP_SG_W];
        end
        if (wr && addr == rirl_pkg::ADDR_RECORD) begin
            d.ext_input_switchgroup = wdata[rirl_pkg::SGB_W-1:0];
        end
        if (wr && addr == rirl_pkg::ADDR_MASK) begin
            d.mask = wdata[rirl_pkg::IRQ_W-1:0];
        end

        // Serial first then second command
        if (serial_a || serial_b) begin
            if (q.serial_second || serial_b) begin
                d.serial_second = 1'b0;
                serial_b = 1'b1;
            end else begin
                d.serial_second = 1'b1;
                serial_a = 1'b1;
            end
        end

        // Bank selection
        if (q.ext_input_switchgroup[rirl_pkg::SGB_BANK_BIT]) begin
            d.bank = ext_any;
        end else if (bank_req_s) begin
            d.bank = bank_val_s;
        end

        // Reset sources ORed per action
        ext_reset_req = ext_any && !q.ext_input_switchgroup[rirl_pkg::SGB_BANK_BIT];
        clr_ind = b_rst || b_prg && dark_s || serial_a || serial_b
            || ext_reset_req && |q.ext_input_switchgroup[rirl_pkg::SGB_ERASE_BIT:rirl_pkg::SGB_IND_BIT];
        clr_unl = (b_prg && dark_s) || serial_a || serial_b
            || ext_reset_req && |q.ext_input_switchgroup[rirl_pkg::SGB_ERASE_BIT:rirl_pkg::SGB_UNL_BIT];
        clr_erase = (b_rst && b_prg) || serial_b
            || ext_reset_req && q.ext_input_switchgroup[rirl_pkg::SGB_ERASE_BIT];

        // Indicators: start codes follow stage unless held
        for (int i = 0; i < NST; i++) begin
            if (st_s[i]) begin
                d.start_ind[i] = 1'b1;
            end else if (!q.start_hold_sg[i] || clr_ind) begin
                d.start_ind[i] = 1'b0;
            end
            if (op_s[i]) begin
                d.oper_ind[i] = 1'b1;
            end else if (clr_ind) begin
                d.oper_ind[i] = 1'b0;
            end
        end

        // Phase lamps latch on any operation
        for (int p = 0; p < NPH; p++) begin
            if (rec_wr && ph_s[p]) begin
                d.phase_ind[p] = 1'b1;
            end else if (b_rst || clr_ind) begin
                d.phase_ind[p] = 1'b0;
            end
        end

        // Held outputs; indicators are not fed back into outputs
        for (int o = 0; o < NOUT; o++) begin
            if (tc_s[o] && q.out_hold_sg[o]) begin
                d.hold_out[o] = 1'b1;
            end else if (clr_unl) begin
                d.hold_out[o] = 1'b0;
            end
        end

        // Shared trip lamp
        if (|(tc_s & q.lamp_sg)) begin
            d.lamp = 1'b1;
        end else if (clr_ind) begin
            d.lamp = 1'b0;
        end

        // Permanent fault, never reset
        if (flt_s && !q.fault) begin
            d.fault = 1'b1;
            d.fcode = fault_code_in;
        end

        if (clr_erase) begin
            d.rec_ptr = '0;
        end else if (rec_wr) begin
            d.rec_ptr = q.rec_ptr + 1'b1;
        end

        // Sticky status, set wins over clear
        if (wr && addr == rirl_pkg::ADDR_STATUS) begin
            d.status = q.status & ~wdata[rirl_pkg::IRQ_W-1:0];
        end
        if (|tc_s) begin
            d.status[rirl_pkg::IRQ_TRIP] = 1'b1;
        end
        if (flt_s && !q.fault) begin
            d.status[rirl_pkg::IRQ_FAULT] = 1'b1;
        end
        if (clr_ind) begin
            d.status[rirl_pkg::IRQ_RESET] = 1'b1;
        end

        if (rd) begin
            unique case (addr)
                rirl_pkg::ADDR_STATUS: d.rdata = {5'h00, q.status};
                rirl_pkg::ADDR_MASK: d.rdata = {5'h00, q.mask};
                rirl_pkg::ADDR_CODE: d.rdata = {4'h0, code};
                rirl_pkg::ADDR_CFG: d.rdata = 8'(q.start_hold_sg);
                rirl_pkg::ADDR_FAULT: d.rdata = q.fcode[7:0];
                rirl_pkg::ADDR_PHASE: d.rdata = 8'({q.fault, q.phase_ind});
                rirl_pkg::ADDR_RECORD: d.rdata = 8'h00;
                rirl_pkg::ADDR_BANK: d.rdata = {q.lamp_sg, q.out_hold_sg};
                default: d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    rirl_record_mem #(
        .DEPTH(REC_DEPTH),
        .WIDTH(8)
    ) u_rec (
        .mclk(mclk),
        .reset(reset),
        .wr_en(rec_wr),
        .wr_addr(q.rec_ptr),
        .wr_data({4'h0, code}),
        .erase(clr_erase),
        .rd_addr(addr[RA-1:0]),
        .rd_data(rec_rd)
    );

    assign rdata = q.rd_rec ? rec_rd : q.rdata;
    assign display_code = code;
    assign trip_lamp = q.lamp;
    assign phase_lamp = q.phase_ind;
    assign trip_out = tc_s | q.hold_out;
    assign internal_fault_lamp = q.fault;
    assign fault_alarm_out = q.fault;
    assign fault_display = {q.fault, q.fcode};
    assign active_bank = q.bank;
    assign irq = |(q.status & q.mask);
endmodule : rirl_indication

// >>> rirl_pkg.sv
// Package for the relay indication and reset logic.
// Assumes one clock domain; consumers reference names with rirl_pkg:: prefix.
package rirl_pkg;
    localparam int NUM_STAGES = 5;          // Low, high, very-high OC, low EF, high EF
    localparam int NUM_OUTS = 4;
    localparam int NUM_PHASES = 3;
    localparam int CODE_W = 4;
    localparam int FAULT_W = 10;
    localparam int MAX_SERIAL_EVENTS = 8;
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_HIGH_EF_START = 4'h9;
    localparam logic [3:0] CODE_HIGH_EF_OPER = 4'hA;
    localparam logic [1:0] BANK_MAIN = 2'h0;
    // Switchgroup bit positions in ext_input_switchgroup
    localparam int SGB_IND_BIT = 0;
    localparam int SGB_UNL_BIT = 1;
    localparam int SGB_ERASE_BIT = 2;
    localparam int SGB_BANK_BIT = 3;
    localparam int SGB_W = 4;
    // Trip lamp mode bits: per-output enable of the lamp
    localparam int LAMP_SG_W = NUM_OUTS;
    // Register offsets on the plain port
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h1;
    localparam logic [3:0] ADDR_CODE = 4'h2;
    localparam logic [3:0] ADDR_CMD = 4'h3;
    localparam logic [3:0] ADDR_CFG = 4'h4;
    localparam logic [3:0] ADDR_FAULT = 4'h5;
    localparam logic [3:0] ADDR_PHASE = 4'h6;
    localparam logic [3:0] ADDR_RECORD = 4'h7;
    localparam logic [3:0] ADDR_BANK = 4'h8;
    // Command bits
    localparam int CMD_RESET_A_BIT = 0;
    localparam int CMD_RESET_B_BIT = 1;
    localparam int CMD_BANK_BIT = 2;
    // Status / interrupt bits
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_RESET = 2;
    localparam int IRQ_W = 3;
    localparam logic [7:0] CFG_RESET = 8'h00;
endpackage : rirl_pkg

// >>> rirl_record_mem.sv
// Small record memory of operate events, register read output.
// Assumes synchronous use on mclk; erase clears all entries.
`timescale 1ns/1ps
module rirl_record_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic erase,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rd_data <= '0;
        end else begin
            if (erase) begin
                for (int i = 0; i < DEPTH; i++) begin
                    mem_q[i] <= '0;
                end
            end else if (wr_en) begin
                mem_q[wr_addr] <= wr_data;
            end
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule : rirl_record_mem

// >>> rirl_bus_model.sv
// Register bus master model for the indication block.
// Assumes the plain strobe port on mclk with read data one cycle after rd.
`timescale 1ns/1ps
module rirl_bus_model (
    input wire logic mclk,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand in the cycle after the strobe, taken at its closing edge
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        d = rdata;
    endtask : rd_reg
endmodule : rirl_bus_model

// >>> rirl_indication_assertions.sv
// Checker for the indication block, bound to its top ports.
// Assumes one clock; any reset request reaches the outputs within 8 cycles.
`timescale 1ns/1ps
module rirl_indication_assertions #(
    parameter int NOUT = rirl_pkg::NUM_OUTS,
    parameter int NPH = rirl_pkg::NUM_PHASES
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [NOUT-1:0] trip_cause,
    input wire logic btn_reset_n,
    input wire logic btn_program_n,
    input wire logic ext_ctrl_in_a,
    input wire logic ext_ctrl_in_b,
    input wire logic ext_remote_reset_in,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [rirl_pkg::CODE_W-1:0] display_code,
    input wire logic trip_lamp,
    input wire logic [NPH-1:0] phase_lamp,
    input wire logic [NOUT-1:0] trip_out,
    input wire logic internal_fault_lamp,
    input wire logic fault_alarm_out,
    input wire logic [rirl_pkg::FAULT_W:0] fault_display
);
    logic [7:0] rst_hist_q;
    logic rst_req;
    // Any source that may clear indicators, loosely
    assign rst_req = !btn_reset_n || !btn_program_n || ext_ctrl_in_a || ext_ctrl_in_b
        || ext_remote_reset_in || wr;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rst_hist_q <= 8'hFF;
        end else begin
            rst_hist_q <= {rst_hist_q[6:0], rst_req};
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_alarm_pair; internal_fault_lamp == fault_alarm_out; endproperty
    a_alarm_pair: assert property (p_alarm_pair)
        else $error("alarm output differs from fault lamp");
    property p_fault_sticky; internal_fault_lamp |=> internal_fault_lamp; endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault lamp cleared");
    property p_fault_code;
        internal_fault_lamp [*3] |-> fault_display[rirl_pkg::FAULT_W] && $stable(fault_display);
    endproperty
    a_fault_code: assert property (p_fault_code)
        else $error("fault code lost its leading one or changed");
    property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
    property p_code_range; display_code <= rirl_pkg::CODE_HIGH_EF_OPER; endproperty
    a_code_range: assert property (p_code_range)
        else $error("display code out of range");
    property p_trip_lamp_hold; $fell(trip_lamp) |-> |rst_hist_q; endproperty
    a_trip_lamp_hold: assert property (p_trip_lamp_hold)
        else $error("trip lamp cleared with no reset");
    property p_phase_hold; |($past(phase_lamp) & ~phase_lamp) |-> |rst_hist_q; endproperty
    a_phase_hold: assert property (p_phase_hold)
        else $error("phase lamp cleared with no reset");
    property p_out_follow; trip_cause[0] [*5] |-> trip_out[0]; endproperty
    a_out_follow: assert property (p_out_follow)
        else $error("trip output not following its cause");
endmodule : rirl_indication_assertions

// >>> tb.sv
// Self-checking bench for the indication block.
// Assumes the bus model drives the register port; pins change at mclk edges.
`timescale 1ns/1ps
module tb;
    logic mclk, reset, btn_reset_n, btn_program_n, display_dark, ext_ctrl_in_a, ext_ctrl_in_b;
    logic [4:0] stage_start, stage_oper;
    logic [2:0] phase_over, phase_lamp;
    logic [3:0] trip_cause, addr, display_code, trip_out;
    logic ext_remote_reset_in, btn_bank_req, btn_bank_val, fault_detect, wr, rd;
    logic trip_lamp, internal_fault_lamp, fault_alarm_out, active_bank, irq;
    logic [9:0] fault_code_in;
    logic [7:0] wdata, rdata, rv;
    logic [10:0] fault_display;
    int fails, n_compared, cyc;
    rirl_indication dut_u (.mclk, .reset, .stage_start, .stage_oper, .phase_over, .trip_cause,
        .btn_reset_n, .btn_program_n, .display_dark, .ext_ctrl_in_a, .ext_ctrl_in_b,
        .ext_remote_reset_in, .btn_bank_req, .btn_bank_val, .fault_detect, .fault_code_in,
        .addr, .wdata, .wr, .rd, .rdata, .display_code, .trip_lamp, .phase_lamp, .trip_out,
        .internal_fault_lamp, .fault_alarm_out, .fault_display, .active_bank, .irq);
    rirl_bus_model bus_u (.mclk, .addr, .wdata, .wr, .rd, .rdata);
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            results();
        end
    end

    task automatic results();
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
    endtask : waitc
    task automatic press(input logic r, input logic p);
        btn_reset_n <= !r;
        btn_program_n <= !p;
        waitc(5);
        btn_reset_n <= 1'b1;
        btn_program_n <= 1'b1;
        waitc(6);
    endtask : press

    task automatic t_codes();
        for (int i = 0; i < 5; i++) begin
            stage_start <= 5'(1 << i);
            waitc(6);
            chk(11'(display_code), 11'(2 * i + 1));
            bus_u.rd_reg(rirl_pkg::ADDR_CODE, rv);
            chk(11'(rv), 11'(2 * i + 1));
            stage_oper <= 5'(1 << i);
            waitc(6);
            chk(11'(display_code), 11'(2 * i + 2));
            stage_start <= 5'h00;
            stage_oper <= 5'h00;
            waitc(6);
            chk(11'(display_code), 11'(2 * i + 2));
            bus_u.wr_reg(rirl_pkg::ADDR_CMD, 8'h01);
            waitc(4);
            chk(11'(display_code), 11'h000);
        end
    endtask : t_codes

    task automatic t_hold();
        stage_start <= 5'h02;
        waitc(6);
        stage_start <= 5'h00;
        waitc(6);
        chk(11'(display_code), 11'h000);
        bus_u.wr_reg(rirl_pkg::ADDR_CFG, 8'h01);
        stage_start <= 5'h01;
        waitc(6);
        stage_start <= 5'h00;
        waitc(6);
        chk(11'(display_code), 11'h001);
        press(1'b1, 1'b0);
        chk(11'(display_code), 11'h000);
        bus_u.wr_reg(rirl_pkg::ADDR_CFG, 8'h00);
    endtask : t_hold

    task automatic t_trip();
        bus_u.wr_reg(rirl_pkg::ADDR_BANK, 8'h11);
        phase_over <= 3'h5;
        {stage_start, stage_oper, trip_cause} <= {5'h01, 5'h01, 4'h1};
        waitc(8);
        {phase_over, stage_start, stage_oper, trip_cause} <= '0;
        waitc(6);
        chk(11'(trip_out), 11'h001);
        chk(11'(trip_lamp), 11'h001);
        chk(11'(phase_lamp), 11'h005);
        press(1'b1, 1'b0);
        chk(11'(phase_lamp), 11'h000);
        chk(11'(trip_lamp), 11'h000);
        chk(11'(trip_out), 11'h001);
        display_dark <= 1'b1;
        press(1'b0, 1'b1);
        chk(11'(trip_out), 11'h000);
        display_dark <= 1'b0;
    endtask : t_trip

    task automatic t_ext();
        logic [7:0] sg[4] = '{8'h00, 8'h01, 8'h02, 8'h04};
        logic exp_out[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic exp_lamp[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++) begin
            trip_cause <= 4'h1;
            waitc(6);
            trip_cause <= 4'h0;
            bus_u.wr_reg(4'h7, sg[i]);
            {ext_remote_reset_in, ext_ctrl_in_b, ext_ctrl_in_a} <= 3'(1 << (i % 3));
            waitc(5);
            {ext_remote_reset_in, ext_ctrl_in_b, ext_ctrl_in_a} <= 3'h0;
            waitc(6);
            chk(11'(trip_out), 11'(exp_out[i]));
            chk(11'(trip_lamp), 11'(exp_lamp[i]));
        end
        bus_u.wr_reg(4'h7, 8'h00);
    endtask : t_ext

    task automatic t_fault();
        fault_code_in <= 10'h2A5;
        fault_detect <= 1'b1;
        waitc(6);
        chk(11'(internal_fault_lamp), 11'h001);
        chk(11'(fault_alarm_out), 11'h001);
        chk(fault_display, 11'h6A5);
        fault_detect <= 1'b0;
        display_dark <= 1'b1;
        press(1'b1, 1'b1);
        bus_u.wr_reg(rirl_pkg::ADDR_CMD, 8'h02);
        waitc(4);
        chk(fault_display, 11'h6A5);
        display_dark <= 1'b0;
        bus_u.wr_reg(rirl_pkg::ADDR_MASK, 8'h00);
        waitc(2);
        chk(11'(irq), 11'h000);
        bus_u.wr_reg(rirl_pkg::ADDR_MASK, 8'h07);
        waitc(2);
        chk(11'(irq), 11'h001);
        bus_u.wr_reg(rirl_pkg::ADDR_STATUS, 8'h05);
        bus_u.rd_reg(rirl_pkg::ADDR_STATUS, rv);
        chk(11'(rv[2:0]), 11'h002);
    endtask : t_fault

    task automatic t_bank();
        bus_u.wr_reg(rirl_pkg::ADDR_CMD, 8'h04);
        waitc(3);
        chk(11'(active_bank), 11'h001);
        bus_u.wr_reg(rirl_pkg::ADDR_CMD, 8'h04);
        waitc(3);
        chk(11'(active_bank), 11'h000);
        btn_bank_req <= 1'b1;
        btn_bank_val <= 1'b1;
        waitc(1);
        btn_bank_req <= 1'b0;
        waitc(2);
        chk(11'(active_bank), 11'h001);
        bus_u.wr_reg(4'h7, 8'h08);
        ext_ctrl_in_a <= 1'b1;
        waitc(6);
        chk(11'(active_bank), 11'h001);
        bus_u.wr_reg(rirl_pkg::ADDR_CMD, 8'h04);
        btn_bank_req <= 1'b1;
        btn_bank_val <= 1'b0;
        waitc(1);
        btn_bank_req <= 1'b0;
        waitc(6);
        chk(11'(active_bank), 11'h001);
        ext_ctrl_in_a <= 1'b0;
        waitc(6);
        chk(11'(active_bank), 11'h000);
        bus_u.wr_reg(4'h7, 8'h00);
    endtask : t_bank

    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        {stage_start, stage_oper, phase_over, trip_cause, fault_code_in} = '0;
        {display_dark, ext_ctrl_in_a, ext_ctrl_in_b, ext_remote_reset_in} = 4'h0;
        {btn_bank_req, btn_bank_val, fault_detect} = 3'h0;
        {btn_reset_n, btn_program_n} = 2'h3;
        waitc(3);
        reset <= 1'b0;
        waitc(2);
        bus_u.rd_reg(4'hF, rv);
        chk(11'(rv), 11'h000);
        t_codes();
        t_hold();
        t_trip();
        t_ext();
        t_fault();
        t_bank();
        results();
    end
endmodule : tb

bind rirl_indication rirl_indication_assertions #(.NOUT(NOUT), .NPH(NPH)) chk_u (.mclk, .reset,
    .trip_cause, .btn_reset_n, .btn_program_n, .ext_ctrl_in_a, .ext_ctrl_in_b,
    .ext_remote_reset_in, .wr, .rd, .rdata, .display_code, .trip_lamp, .phase_lamp, .trip_out,
    .internal_fault_lamp, .fault_alarm_out, .fault_display);
